// ### rtl/csdt_pkg.sv
// package: register map, encodings, types and state of the datapath
package csdt_pkg;

  // ----
  // register byte offsets on the AHB-Lite slave
  // ----
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_OPCODE = 8'h04;
  localparam logic [7:0] ADR_FLAGS_IN = 8'h08;
  localparam logic [7:0] ADR_DEST = 8'h0C;
  localparam logic [7:0] ADR_SRC = 8'h10;
  localparam logic [7:0] ADR_COUNT = 8'h14;
  localparam logic [7:0] ADR_GBASE = 8'h18;
  localparam logic [7:0] ADR_GLIMIT = 8'h1C;
  localparam logic [7:0] ADR_IBASE = 8'h20;
  localparam logic [7:0] ADR_ILIMIT = 8'h24;
  localparam logic [7:0] ADR_EADDR = 8'h28;
  localparam logic [7:0] ADR_STATUS = 8'h2C;
  localparam logic [7:0] ADR_RESULT = 8'h30;
  localparam logic [7:0] ADR_FLAGS_OUT = 8'h34;
  localparam logic [7:0] ADR_MEM_LO = 8'h38;
  localparam logic [7:0] ADR_MEM_HI = 8'h3C;

  // ----
  // opcodes (second byte after 0F), table selectors, modes
  // ----
  localparam logic [3:0] OPC_SET_GROUP = 4'h9;
  localparam logic [7:0] OPC_TABLE = 8'h01;
  localparam logic [7:0] OPC_DSHL_IMM = 8'hA4;
  localparam logic [7:0] OPC_DSHL_RG = 8'hA5;
  localparam logic [2:0] SEL_GLOBAL = 3'h0;
  localparam logic [2:0] SEL_INTR = 3'h1;
  localparam logic [1:0] MODE_REAL = 2'h0;
  localparam logic [1:0] MODE_PROT = 2'h1;
  localparam logic [1:0] MODE_V86 = 2'h2;
  localparam logic [1:0] CPL_USER = 2'h3;

  // flag bit positions in the flag word
  localparam int FLG_CY = 0;
  localparam int FLG_PA = 2;
  localparam int FLG_HC = 4;
  localparam int FLG_ZR = 6;
  localparam int FLG_SG = 7;
  localparam int FLG_OV = 11;

  // operand sizes in bytes and address space top for real/v86
  localparam logic [2:0] NB_BYTE = 3'h1;
  localparam logic [2:0] NB_WORD = 3'h2;
  localparam logic [2:0] NB_DWORD = 3'h4;
  localparam logic [2:0] NB_TABLE = 3'h6;
  localparam logic [32:0] REAL_TOP = 33'h00000FFFF;
  localparam logic [31:0] BASE16_MASK = 32'h00FFFFFF;
  localparam logic [7:0] VEC_INVOP = 8'h06;
  localparam logic [7:0] VEC_PR = 8'h0D;
  localparam logic [7:0] VEC_SS = 8'h0C;
  localparam logic [7:0] VEC_PG = 8'h0E;
  localparam logic [7:0] VEC_AL = 8'h11;

  // ----
  // types
  // ----
  typedef enum logic [2:0] {EXC_NONE, EXC_INVOP, EXC_PR, EXC_SS, EXC_PG, EXC_AL, EXC_RM13} csdt_exc_t;
  typedef enum logic {FSM_IDLE, FSM_EXEC} csdt_fsm_t;

  typedef struct packed {
    logic [19:0] rsv;
    logic unaligned;
    logic page_miss;
    logic stack_bad;
    logic ea_bad;
    logic nonwritable;
    logic dest_is_reg;
    logic [1:0] cpl;
    logic [1:0] mode;
    logic op32;
    logic start;
  } csdt_ctrl_t;

  typedef struct packed {
    logic [20:0] rsv;
    logic [2:0] sel;
    logic [7:0] op;
  } csdt_opc_t;

  typedef struct packed {
    logic [15:0] rsv;
    logic [7:0] rg;
    logic [7:0] imm;
  } csdt_cnt_t;

  typedef struct packed {
    logic [15:0] rsv;
    logic [7:0] vector;
    logic rsv2;
    csdt_exc_t exc;
    logic flags_wr;
    logic dest_wr;
    logic busy;
    logic done;
  } csdt_status_t;

  // hready is the top bit so the reset constant can set it alone
  typedef struct packed {
    logic hready;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [7:0] wr_addr;
    csdt_fsm_t fsm;
    csdt_ctrl_t ctrl;
    csdt_opc_t opc;
    logic [31:0] flags_in;
    logic [31:0] dest;
    logic [31:0] src;
    csdt_cnt_t cnt;
    logic [31:0] gbase;
    logic [15:0] glimit;
    logic [31:0] ibase;
    logic [15:0] ilimit;
    logic [31:0] eaddr;
    csdt_status_t status;
    logic [31:0] result;
    logic [31:0] flags_out;
    logic [31:0] mem_lo;
    logic [31:0] mem_hi;
  } csdt_state_t;

  localparam int ST_W = $bits(csdt_state_t);
  localparam csdt_state_t ST_RESET = csdt_state_t'({1'b1, {(ST_W - 1){1'b0}}});

endpackage

// ### rtl/csdt_cond.sv
// condition evaluator for the conditional byte set group
`timescale 1ns/100ps
module csdt_cond (
  input wire logic [3:0] cc,
  input wire logic cy,
  input wire logic pa,
  input wire logic zr,
  input wire logic sg,
  input wire logic ov,
  output logic hit
);

  // ----
  // low nibble of 0F 9x selects the test
  // ----
  always_comb begin
    case (cc)
      4'h0: hit = ov;
      4'h1: hit = ~ov;
      4'h2: hit = cy;
      4'h3: hit = ~cy;
      4'h4: hit = zr;
      4'h5: hit = ~zr;
      4'h6: hit = cy | zr;
      4'h7: hit = ~cy & ~zr;
      4'h8: hit = sg;
      4'h9: hit = ~sg;
      4'hA: hit = pa;
      4'hB: hit = ~pa;
      4'hC: hit = sg ^ ov;
      4'hD: hit = ~(sg ^ ov);
      4'hE: hit = zr | (sg ^ ov);
      4'hF: hit = ~zr & ~(sg ^ ov);
      default: hit = 1'b0;
    endcase
  end

endmodule // csdt_cond

// ### rtl/csdt_dshift.sv
// left double shift unit with result flags
`timescale 1ns/100ps
module csdt_dshift (
  input wire logic [31:0] dest,
  input wire logic [31:0] src,
  input wire logic [4:0] cnt,
  input wire logic op32,
  output logic [31:0] result,
  output logic cy,
  output logic ov,
  output logic sg,
  output logic zr,
  output logic pa
);

  logic [64:0] wide;
  logic [31:0] top;

  // ----
  // operands packed at the top of one word so 16 and 32 share a shifter;
  // the source only feeds the shifter and is never written back
  // ----
  always_comb begin
    if (op32) begin
      wide = {1'b0, dest, src} << cnt;
    end else begin
      wide = {1'b0, dest[15:0], src[15:0], 32'h00000000} << cnt;
    end
    top = wide[63:32];
    result = op32 ? top : {16'h0000, top[31:16]};
    cy = wide[64];
    ov = wide[64] ^ top[31];
    sg = top[31];
    zr = op32 ? (top == 32'h00000000) : (top[31:16] == 16'h0000);
    pa = ~^result[7:0];
  end

endmodule // csdt_dshift

// ### rtl/csdt_top.sv
// top: AHB-Lite register slave and execution of byte set, table store and left double shift
`timescale 1ns/100ps
module csdt_top (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic DONE,
  output logic DEST_WRITE,
  output logic [7:0] FAULT_VECTOR
);

  // ----------------------------------------------------------------
  // state and helper signals
  // ----------------------------------------------------------------
  csdt_pkg::csdt_state_t s_q;
  csdt_pkg::csdt_state_t s_d;
  csdt_pkg::csdt_ctrl_t wctl;
  csdt_pkg::csdt_exc_t exc;
  logic bus_take;
  logic addr_ok;
  logic cond_hit;
  logic [7:0] op;
  logic is_set;
  logic is_table;
  logic is_dshl;
  logic [4:0] shamt;
  logic [2:0] nbytes;
  logic [31:0] sh_result;
  logic sh_cy;
  logic sh_ov;
  logic sh_sg;
  logic sh_zr;
  logic sh_pa;
  logic [31:0] tbl_base;
  logic [15:0] tbl_limit;
  logic [31:0] exe_result;
  logic [31:0] exe_flags;
  logic [31:0] exe_mem_lo;
  logic [31:0] exe_mem_hi;
  logic exe_dest_wr;
  logic exe_flags_wr;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // read mux; unmapped words read as zero
  function automatic logic [31:0] rd_word(input csdt_pkg::csdt_state_t s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h00000000;
    case (a)
      csdt_pkg::ADR_CTRL: v = s.ctrl;
      csdt_pkg::ADR_OPCODE: v = s.opc;
      csdt_pkg::ADR_FLAGS_IN: v = s.flags_in;
      csdt_pkg::ADR_DEST: v = s.dest;
      csdt_pkg::ADR_SRC: v = s.src;
      csdt_pkg::ADR_COUNT: v = s.cnt;
      csdt_pkg::ADR_GBASE: v = s.gbase;
      csdt_pkg::ADR_GLIMIT: v = {16'h0000, s.glimit};
      csdt_pkg::ADR_IBASE: v = s.ibase;
      csdt_pkg::ADR_ILIMIT: v = {16'h0000, s.ilimit};
      csdt_pkg::ADR_EADDR: v = s.eaddr;
      csdt_pkg::ADR_STATUS: v = s.status;
      csdt_pkg::ADR_RESULT: v = s.result;
      csdt_pkg::ADR_FLAGS_OUT: v = s.flags_out;
      csdt_pkg::ADR_MEM_LO: v = s.mem_lo;
      csdt_pkg::ADR_MEM_HI: v = s.mem_hi;
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction

  // fault vector for each exception class
  function automatic logic [7:0] vec_of(input csdt_pkg::csdt_exc_t e);
    logic [7:0] v;
    v = 8'h00;
    case (e)
      csdt_pkg::EXC_INVOP: v = csdt_pkg::VEC_INVOP;
      csdt_pkg::EXC_PR: v = csdt_pkg::VEC_PR;
      csdt_pkg::EXC_SS: v = csdt_pkg::VEC_SS;
      csdt_pkg::EXC_PG: v = csdt_pkg::VEC_PG;
      csdt_pkg::EXC_AL: v = csdt_pkg::VEC_AL;
      csdt_pkg::EXC_RM13: v = csdt_pkg::VEC_PR;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // arithmetic units
  // ----------------------------------------------------------------
  csdt_cond u_cond (
    .cc(s_q.opc.op[3:0]),
    .cy(s_q.flags_in[csdt_pkg::FLG_CY]),
    .pa(s_q.flags_in[csdt_pkg::FLG_PA]),
    .zr(s_q.flags_in[csdt_pkg::FLG_ZR]),
    .sg(s_q.flags_in[csdt_pkg::FLG_SG]),
    .ov(s_q.flags_in[csdt_pkg::FLG_OV]),
    .hit(cond_hit)
  );

  csdt_dshift u_dshift (
    .dest(s_q.dest),
    .src(s_q.src),
    .cnt(shamt),
    .op32(s_q.ctrl.op32),
    .result(sh_result),
    .cy(sh_cy),
    .ov(sh_ov),
    .sg(sh_sg),
    .zr(sh_zr),
    .pa(sh_pa)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // only single word transfers are expected; any other size is still taken as a word
  assign bus_take = HSEL & HREADY & HTRANS[1];
  assign addr_ok = (HADDR[31:8] == 24'h000000) && (HADDR[1:0] == 2'h0);
  assign wctl = csdt_pkg::csdt_ctrl_t'(HWDATA);

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  always_comb begin
    op = s_q.opc.op;
    is_set = (op[7:4] == csdt_pkg::OPC_SET_GROUP);
    is_table = (op == csdt_pkg::OPC_TABLE) &&
      ((s_q.opc.sel == csdt_pkg::SEL_GLOBAL) || (s_q.opc.sel == csdt_pkg::SEL_INTR));
    is_dshl = (op == csdt_pkg::OPC_DSHL_IMM) || (op == csdt_pkg::OPC_DSHL_RG);
    // count source by opcode, then reduced modulo 32
    shamt = (op == csdt_pkg::OPC_DSHL_RG) ? s_q.cnt.rg[4:0] : s_q.cnt.imm[4:0];
    if (is_table) begin
      nbytes = csdt_pkg::NB_TABLE;
    end else if (is_dshl) begin
      nbytes = s_q.ctrl.op32 ? csdt_pkg::NB_DWORD : csdt_pkg::NB_WORD;
    end else begin
      nbytes = csdt_pkg::NB_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // exception check, fixed priority: invalid opcode, then access faults
  // ----------------------------------------------------------------
  always_comb begin
    logic [32:0] last_byte;
    logic user;
    last_byte = {1'b0, s_q.eaddr} + {30'h00000000, nbytes} - 33'h000000001;
    user = (s_q.ctrl.cpl == csdt_pkg::CPL_USER);
    exc = csdt_pkg::EXC_NONE;
    if (!(is_set || is_table || is_dshl)) begin
      exc = csdt_pkg::EXC_INVOP;
    end else if (is_table && s_q.ctrl.dest_is_reg) begin
      exc = csdt_pkg::EXC_INVOP;
    end else if (!s_q.ctrl.dest_is_reg) begin
      if (s_q.ctrl.mode == csdt_pkg::MODE_PROT) begin
        if (s_q.ctrl.nonwritable || s_q.ctrl.ea_bad) begin
          exc = csdt_pkg::EXC_PR;
        end else if (s_q.ctrl.stack_bad) begin
          exc = csdt_pkg::EXC_SS;
        end else if (s_q.ctrl.page_miss) begin
          exc = csdt_pkg::EXC_PG;
        end else if (s_q.ctrl.unaligned && user) begin
          exc = csdt_pkg::EXC_AL;
        end
      end else begin
        // real and v86 share the 64K window check; v86 adds paging and alignment
        if (last_byte > csdt_pkg::REAL_TOP) begin
          exc = csdt_pkg::EXC_RM13;
        end else if ((s_q.ctrl.mode == csdt_pkg::MODE_V86) && s_q.ctrl.page_miss) begin
          exc = csdt_pkg::EXC_PG;
        end else if ((s_q.ctrl.mode == csdt_pkg::MODE_V86) && s_q.ctrl.unaligned && user) begin
          exc = csdt_pkg::EXC_AL;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // results per instruction group
  // ----------------------------------------------------------------
  always_comb begin
    tbl_base = (s_q.opc.sel == csdt_pkg::SEL_INTR) ? s_q.ibase : s_q.gbase;
    tbl_limit = (s_q.opc.sel == csdt_pkg::SEL_INTR) ? s_q.ilimit : s_q.glimit;
    if (!s_q.ctrl.op32) begin
      tbl_base = tbl_base & csdt_pkg::BASE16_MASK;
    end
    exe_result = s_q.dest;
    exe_flags = s_q.flags_in;
    exe_mem_lo = 32'h00000000;
    exe_mem_hi = 32'h00000000;
    exe_dest_wr = 1'b0;
    exe_flags_wr = 1'b0;
    if (exc != csdt_pkg::EXC_NONE) begin
      // a faulting instruction leaves destination and flags alone
      exe_dest_wr = 1'b0;
    end else if (is_set) begin
      exe_result = {31'h00000000, cond_hit};
      exe_dest_wr = 1'b1;
    end else if (is_table) begin
      // limit in bytes 0-1, base in bytes 2-5
      exe_mem_lo = {tbl_base[15:0], tbl_limit};
      exe_mem_hi = {16'h0000, tbl_base[31:16]};
      exe_dest_wr = 1'b1;
    end else if (shamt != 5'h00) begin
      // counts at or past the width still go through the shifter: defined, no fault
      exe_result = sh_result;
      exe_flags[csdt_pkg::FLG_CY] = sh_cy;
      exe_flags[csdt_pkg::FLG_OV] = sh_ov;
      exe_flags[csdt_pkg::FLG_SG] = sh_sg;
      exe_flags[csdt_pkg::FLG_ZR] = sh_zr;
      exe_flags[csdt_pkg::FLG_PA] = sh_pa;
      exe_dest_wr = 1'b1;
      exe_flags_wr = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // next state: bus slave and execution sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.hready = 1'b1;
    // address phase: reads answer with zero wait, writes land in the data phase
    s_d.wr_pend = bus_take & HWRITE & addr_ok;
    s_d.wr_addr = HADDR[7:0];
    if (bus_take && !HWRITE) begin
      s_d.hrdata = addr_ok ? rd_word(s_q, HADDR[7:0]) : 32'h00000000;
    end
    // operand writes are ignored during the single execute cycle
    if (s_q.wr_pend && (s_q.fsm == csdt_pkg::FSM_IDLE)) begin
      case (s_q.wr_addr)
        csdt_pkg::ADR_CTRL: begin
          s_d.ctrl = wctl;
          s_d.ctrl.start = 1'b0;
          s_d.ctrl.rsv = 20'h00000;
          if (wctl.start) begin
            s_d.fsm = csdt_pkg::FSM_EXEC;
            s_d.status.done = 1'b0;
            s_d.status.busy = 1'b1;
          end
        end
        csdt_pkg::ADR_OPCODE: begin
          s_d.opc = HWDATA;
          s_d.opc.rsv = 21'h000000;
        end
        csdt_pkg::ADR_FLAGS_IN: s_d.flags_in = HWDATA;
        csdt_pkg::ADR_DEST: s_d.dest = HWDATA;
        csdt_pkg::ADR_SRC: s_d.src = HWDATA;
        csdt_pkg::ADR_COUNT: begin
          s_d.cnt = HWDATA;
          s_d.cnt.rsv = 16'h0000;
        end
        csdt_pkg::ADR_GBASE: s_d.gbase = HWDATA;
        csdt_pkg::ADR_GLIMIT: s_d.glimit = HWDATA[15:0];
        csdt_pkg::ADR_IBASE: s_d.ibase = HWDATA;
        csdt_pkg::ADR_ILIMIT: s_d.ilimit = HWDATA[15:0];
        csdt_pkg::ADR_EADDR: s_d.eaddr = HWDATA;
        default: s_d.fsm = s_q.fsm;
      endcase
    end
    // execute cycle: latch every outcome at once
    case (s_q.fsm)
      csdt_pkg::FSM_IDLE: s_d.status.busy = s_d.status.busy;
      csdt_pkg::FSM_EXEC: begin
        s_d.fsm = csdt_pkg::FSM_IDLE;
        s_d.status.busy = 1'b0;
        s_d.status.done = 1'b1;
        s_d.status.exc = exc;
        s_d.status.vector = vec_of(exc);
        s_d.status.dest_wr = exe_dest_wr;
        s_d.status.flags_wr = exe_flags_wr;
        s_d.result = exe_result;
        s_d.flags_out = exe_flags;
        s_d.mem_lo = exe_mem_lo;
        s_d.mem_hi = exe_mem_hi;
      end
      default: s_d.fsm = csdt_pkg::FSM_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      s_q <= csdt_pkg::ST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign HRDATA = s_q.hrdata;
  assign HREADYOUT = s_q.hready;
  assign HRESP = s_q.status.rsv2;
  assign DONE = s_q.status.done;
  assign DEST_WRITE = s_q.status.dest_wr;
  assign FAULT_VECTOR = s_q.status.vector;

endmodule // csdt_top

// ### test/csdt_monitor.sv
// checker for the bus and result ports of the datapath
`timescale 1ns/100ps
module csdt_monitor (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic DONE,
  input wire logic DEST_WRITE,
  input wire logic [7:0] FAULT_VECTOR
);
  logic wr_q, rd_q, ex_q, st, bs, zc;
  logic [7:0] a_q, op_q;
  logic [15:0] ct_q, cn_q;
  logic [31:0] fl_q, ea_q;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // ----
  // shadow of the operands last written
  // ----
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      {wr_q, rd_q, ex_q, a_q, op_q, ct_q, cn_q, fl_q, ea_q} <= '0;
    end else begin
      wr_q <= HSEL && HREADY && HTRANS[1] && HWRITE;
      rd_q <= HSEL && HREADY && HTRANS[1] && !HWRITE;
      a_q <= HADDR[7:0];
      ex_q <= st;
      if (wr_q && a_q == csdt_pkg::ADR_OPCODE) op_q <= HWDATA[7:0];
      if (wr_q && a_q == csdt_pkg::ADR_CTRL) ct_q <= HWDATA[15:0];
      if (wr_q && a_q == csdt_pkg::ADR_COUNT) cn_q <= HWDATA[15:0];
      if (wr_q && a_q == csdt_pkg::ADR_FLAGS_IN) fl_q <= HWDATA;
      if (wr_q && a_q == csdt_pkg::ADR_EADDR) ea_q <= HWDATA;
    end
  end
  // start shows at the data edge of a ctrl write; zero count depends on the count source
  assign st = wr_q && a_q == csdt_pkg::ADR_CTRL && HWDATA[0];
  assign bs = op_q[7:4] == csdt_pkg::OPC_SET_GROUP;
  assign zc = op_q == csdt_pkg::OPC_DSHL_IMM ? cn_q[4:0] == 5'h0
            : op_q == csdt_pkg::OPC_DSHL_RG && cn_q[12:8] == 5'h0;
  // ----
  // assertions
  // ----
  start_done_a:
    assert property (st |=> !DONE ##1 DONE) else $error("done not one edge after start");
  result_hold_a:
    assert property (!st && !ex_q |=> $stable(FAULT_VECTOR) && $stable(DEST_WRITE)) else $error("result moved");
  set_write_a:
    assert property ($rose(DONE) && bs && FAULT_VECTOR == 8'h00 |-> DEST_WRITE) else $error("byte set no write");
  zero_count_a:
    assert property ($rose(DONE) && zc |-> !DEST_WRITE) else $error("zero count wrote");
  reg_table_a:
    assert property ($rose(DONE) && op_q == csdt_pkg::OPC_TABLE && ct_q[6] |-> FAULT_VECTOR == csdt_pkg::VEC_INVOP)
      else $error("table store to register");
  prot_fault_a:
    assert property ($rose(DONE) && bs && ct_q[3:2] == csdt_pkg::MODE_PROT && !ct_q[6] && |ct_q[8:7]
      |-> FAULT_VECTOR == csdt_pkg::VEC_PR) else $error("protection fault missed");
  real_range_a:
    assert property ($rose(DONE) && bs && ct_q[3:2] == csdt_pkg::MODE_REAL && !ct_q[6] && ea_q > 32'h0000FFFF
      |-> FAULT_VECTOR == csdt_pkg::VEC_PR) else $error("range fault missed");
  set_value_a:
    assert property (rd_q && a_q == csdt_pkg::ADR_RESULT && DONE && bs && FAULT_VECTOR == 8'h00
      |-> HRDATA[31:1] == 31'h0) else $error("byte set value");
  flags_keep_a:
    assert property (rd_q && a_q == csdt_pkg::ADR_FLAGS_OUT && DONE
      && (bs || op_q == csdt_pkg::OPC_TABLE || FAULT_VECTOR != 8'h00) |-> HRDATA == fl_q) else $error("flags moved");
  cover property (st);
  cover property ($rose(DONE) && DEST_WRITE);
  cover property ($rose(DONE) && FAULT_VECTOR == csdt_pkg::VEC_INVOP);
endmodule // csdt_monitor

// ### test/csdt_host.sv
// bus master standing for the decoder and operand path
`timescale 1ns/100ps
module csdt_host (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // quiet bus from time zero
  initial begin
    {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
  end
  // one word transfer; each phase held until hready is seen high, no cycle count assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata; // reads get a changing pattern, not stale data
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule // csdt_host

// ### test/tb_condset_dblshift_tablestore.sv
// self-checking bench for the byte set, table store and left double shift datapath
`timescale 1ns/100ps
module tb_condset_dblshift_tablestore;
  typedef struct packed {logic [7:0] op; logic w; logic [31:0] d, s; logic [15:0] cn;} csdt_sh_t;
  typedef struct packed {logic [15:0] op, ct; logic [31:0] ea; logic [7:0] v;} csdt_ft_t;
  logic clk_sys, nrst, hready, hsel, hwrite, hresp, done, dest_write;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] fault_vector;
  int num_errors, total_checks, cycles;
  // shift cases: imm and reg counts differ so a wrong pick shows
  csdt_sh_t sh [8] = '{'{8'hA4, 1'b1, 32'h12345678, 32'h9ABCDEF0, 16'h0704},
    '{8'hA5, 1'b1, 32'h80000000, 32'h0, 16'h0104}, '{8'hA4, 1'b1, 32'h40000001, 32'hFFFFFFFF, 16'h0021},
    '{8'hA5, 1'b0, 32'hFFFFF00F, 32'h0000A000, 16'h0300}, '{8'hA4, 1'b1, 32'h0000ABCD, 32'h12345678, 16'h001F},
    '{8'hA4, 1'b1, 32'hDEADBEEF, 32'h0, 16'h0520}, '{8'hA5, 1'b1, 32'hDEADBEEF, 32'h0, 16'h0009},
    '{8'hA5, 1'b0, 32'h1234, 32'h5678, 16'h1400}};
  // fault cases: ctrl bits 3:2 mode, 5:4 level, 6 register dest, 7..11 fault inputs
  csdt_ft_t ft [16] = '{'{16'h97, 16'h84, 32'h100, 8'h0D}, '{16'h97, 16'h104, 32'h100, 8'h0D},
    '{16'h97, 16'h204, 32'h100, 8'h0C}, '{16'h97, 16'h404, 32'h100, 8'h0E}, '{16'h97, 16'h834, 32'h101, 8'h11},
    '{16'h97, 16'h804, 32'h101, 8'h00}, '{16'h97, 16'h0, 32'hFFFF, 8'h00}, '{16'h97, 16'h0, 32'h10000, 8'h0D},
    '{16'h97, 16'h408, 32'h100, 8'h0E}, '{16'h01, 16'h0, 32'hFFFA, 8'h00}, '{16'h01, 16'h0, 32'hFFFB, 8'h0D},
    '{16'h01, 16'h40, 32'h100, 8'h06}, '{16'h01, 16'h44, 32'h100, 8'h06}, '{16'h01, 16'h48, 32'h100, 8'h06},
    '{16'h55, 16'h40, 32'h0, 8'h06}, '{16'h201, 16'h0, 32'h100, 8'h06}};
  csdt_host host (.clk(clk_sys), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  csdt_top uut (.CLK_SYS(clk_sys), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .DONE(done), .DEST_WRITE(dest_write), .FAULT_VECTOR(fault_vector));
  // ----
  // clock, hang limit and helpers
  // ----
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    host.xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    host.xfer(1'b0, a, 32'h0, d);
  endtask
  // f is {ov, sg, zr, pa, cy}; aux carry rides along so its keeping is seen too
  function automatic logic [31:0] fword(input logic [4:0] f);
    logic [31:0] w;
    w = 32'h0;
    w[csdt_pkg::FLG_CY] = f[0];
    w[csdt_pkg::FLG_PA] = f[1];
    w[csdt_pkg::FLG_ZR] = f[2];
    w[csdt_pkg::FLG_SG] = f[3];
    w[csdt_pkg::FLG_OV] = f[4];
    w[csdt_pkg::FLG_HC] = f[0] ^ f[3];
    return w;
  endfunction
  function automatic logic cexp(input logic [3:0] c, input logic [4:0] f);
    logic [7:0] t;
    t = {f[2] | (f[3] ^ f[4]), f[3] ^ f[4], f[1], f[3], f[0] | f[2], f[2], f[0], f[4]};
    return t[c[3:1]] ^ c[0];
  endfunction
  function automatic logic [31:0] dshl(input logic w, input logic [31:0] d, s, input int n, output logic [4:0] f);
    logic [64:0] x;
    logic [31:0] r;
    x = w ? {1'b0, d, s} : {33'h0, d[15:0], s[15:0]};
    x = x << n;
    r = w ? x[63:32] : {16'h0, x[31:16]};
    f[0] = x[w ? 64 : 32];
    f[3] = r[w ? 31 : 15];
    f[2] = r == 32'h0;
    f[1] = ~^r[7:0];
    f[4] = f[3] ^ f[0];
    return r;
  endfunction
  // program operands, start, then poll status until done
  task automatic run(input logic [31:0] op, fl, de, sr, cn, ct, ea);
    int n;
    wr(csdt_pkg::ADR_OPCODE, op);
    wr(csdt_pkg::ADR_FLAGS_IN, fl);
    wr(csdt_pkg::ADR_DEST, de);
    wr(csdt_pkg::ADR_SRC, sr);
    wr(csdt_pkg::ADR_COUNT, cn);
    wr(csdt_pkg::ADR_EADDR, ea);
    wr(csdt_pkg::ADR_CTRL, ct | 32'h1);
    n = 0;
    q = 32'h0;
    while (q[0] !== 1'b1 && n < 20) begin
      rd(csdt_pkg::ADR_STATUS, q);
      n++;
    end
    chk({29'h0, hresp, done, q[0]}, 32'h3);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    csdt_sh_t s;
    csdt_ft_t e;
    logic [31:0] r, m;
    logic [4:0] f;
    int n;
    nrst = 1'b0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(csdt_pkg::ADR_STATUS, q);
    chk(q, 32'h0);
    rd(8'h40, q);
    chk(q, 32'h0);
    // every condition code against every flag pattern, register destination
    for (int c = 0; c < 16; c++) begin
      for (int k = 0; k < 32; k++) begin
        run({24'h0, csdt_pkg::OPC_SET_GROUP, c[3:0]}, fword(k[4:0]), 32'hFFFFFF5A, 32'h0, 32'h0, 32'h40, 32'h0);
        rd(csdt_pkg::ADR_RESULT, q);
        chk(q, {31'h0, cexp(c[3:0], k[4:0])});
        rd(csdt_pkg::ADR_FLAGS_OUT, q);
        chk(q, fword(k[4:0]));
        chk({31'h0, dest_write}, 32'h1);
      end
    end
    wr(csdt_pkg::ADR_GBASE, 32'hA1B2C3D4);
    wr(csdt_pkg::ADR_GLIMIT, 32'h1234);
    wr(csdt_pkg::ADR_IBASE, 32'h5E6F7081);
    wr(csdt_pkg::ADR_ILIMIT, 32'h0ABC);
    for (int t = 0; t < 4; t++) begin
      r = t[1] ? 32'h5E6F7081 : 32'hA1B2C3D4;
      run({23'h0, t[1], csdt_pkg::OPC_TABLE}, fword(5'h0A), 32'h0, 32'h0, 32'h0, {30'h0, t[0], 1'b0}, 32'h100);
      rd(csdt_pkg::ADR_MEM_LO, q);
      chk(q, {r[15:0], t[1] ? 16'h0ABC : 16'h1234});
      rd(csdt_pkg::ADR_MEM_HI, q);
      chk({16'h0, q[15:0]}, {16'h0, t[0] ? r[31:24] : 8'h00, r[23:16]});
      rd(csdt_pkg::ADR_FLAGS_OUT, q);
      chk(q, fword(5'h0A));
    end
    for (int i = 0; i < 8; i++) begin
      s = sh[i];
      n = s.op == csdt_pkg::OPC_DSHL_IMM ? s.cn[4:0] : s.cn[12:8];
      r = dshl(s.w, s.d, s.s, n, f);
      m = fword({n == 1, 4'hF});
      run({24'h0, s.op}, fword(5'h15), s.d, s.s, {16'h0, s.cn}, {25'h0, 1'b1, 4'h0, s.w, 1'b0}, 32'h0);
      chk({24'h0, fault_vector}, 32'h0);
      rd(csdt_pkg::ADR_SRC, q);
      chk(q, s.s);
      rd(csdt_pkg::ADR_FLAGS_OUT, q);
      if (n == 0) begin
        chk(q, fword(5'h15));
        chk({31'h0, dest_write}, 32'h0);
      end else if (s.w || n < 16) begin
        chk(q & m, fword(f) & m);
        rd(csdt_pkg::ADR_RESULT, q);
        chk(q, r);
      end
    end
    // faults by mode and cause; a faulting byte set must not write
    foreach (ft[i]) begin
      e = ft[i];
      run({16'h0, e.op}, 32'h0, 32'h0, 32'h0, 32'h0, {16'h0, e.ct}, e.ea);
      chk({24'h0, fault_vector}, {24'h0, e.v});
      if (e.v != 8'h00 || e.op[7:4] == 4'h9) chk({31'h0, dest_write}, {31'h0, e.v == 8'h00});
    end
    final_report();
  end
endmodule // tb_condset_dblshift_tablestore
bind csdt_top csdt_monitor mon (.CLK_SYS(CLK_SYS), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .DONE(DONE), .DEST_WRITE(DEST_WRITE),
  .FAULT_VECTOR(FAULT_VECTOR));
